// File: src/dir_regs.sv
// apb register bank: identity bytes, cell identity bytes, burst planning
//
// Our own choice: the APB register port.
`timescale 1ns/1ps

module dir_regs
    import dir_pkg::*;
#(
    parameter logic [PRODUCT_W-1:0]    PRODUCT_CODE    = 12'h3a7,      // arbitrary value
    parameter logic [ORIGINATOR_W-1:0] ORIGINATOR_CODE = 8'h5c,        // arbitrary value
    parameter logic [REVISION_W-1:0]   REVISION        = 4'h2,         // arbitrary value
    parameter logic [DATA_W-1:0]       CELL_IDENT_WORD = 32'h6e2d_c93a // arbitrary value
) (
    // clock, reset, enable
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              ce,
    // apb request
    input  wire dir_apb_req_s      apb_req,
    // apb answer
    output logic [DATA_W-1:0]      prdata,
    output logic                   pready,
    output logic                   pslverr,
    // burst plan towards the channel engine
    output dir_burst_s             burst_plan
);

    ////////////////////////////////////////////////////////////////////////////
    // fixed identity content

    // configuration byte assembled from its encodings
    localparam logic [CONFIG_W-1:0] CONFIG_BYTE = {CFG_REQ_16, CFG_WIDTH_32,
                                                   CFG_MASTERS_1, CFG_CHAN_2};

    // whole identity word, fields packed at their positions
    localparam logic [DATA_W-1:0] IDENT_WORD = {CONFIG_BYTE, REVISION,
                                                ORIGINATOR_CODE, PRODUCT_CODE};

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [DATA_W-1:0] burst_ctrl_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic              pready_reg;
    logic              pslverr_reg;
    logic              pslverr_next;
    dir_burst_s        plan_reg;
    dir_burst_s        plan_next;
    logic              setup_phase;
    logic              access_done;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // pick byte n (0..3) of a word, placed in the low bits
    function automatic logic [DATA_W-1:0] byte_of(input logic [DATA_W-1:0] word, input logic [1:0] n);
        logic [7:0] b;
        b = word[{n, 3'h0} +: 8];
        return {24'h00_0000, b};
    endfunction

    // burst choice from size, same-port flag and remaining beats
    function automatic dir_burst_s plan_burst(input dir_size_e size, input logic same,
                                              input logic [BC_COUNT_W-1:0] count);
        dir_burst_s p;
        p.kind  = KIND_SINGLE;
        p.beats = BEATS_SINGLE;
        if (same && size == SIZE_WORD && count >= 16'(BEATS_WORD)) begin
            p.kind  = KIND_INCR4;
            p.beats = BEATS_WORD;
        end else if (same && size == SIZE_HALF && count >= 16'(BEATS_HALF)) begin
            p.kind  = KIND_INCR8;
            p.beats = BEATS_HALF;
        end
        // byte transfers fall to single beats, never a sixteen-beat burst
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb phase decode

    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign access_done = apb_req.psel && apb_req.penable && pready_reg;

    ////////////////////////////////////////////////////////////////////////////
    // read data and error decode, prepared during setup
    always_comb begin
        prdata_next  = 32'h0000_0000;
        pslverr_next = 1'b0;
        unique case (apb_req.paddr)
            OFS_DMA_IDENT_BYTE0:  prdata_next = byte_of(IDENT_WORD, 2'h0);
            OFS_DMA_IDENT_BYTE1:  prdata_next = byte_of(IDENT_WORD, 2'h1);
            OFS_DMA_IDENT_BYTE2:  prdata_next = byte_of(IDENT_WORD, 2'h2);
            OFS_DMA_CONFIG_BYTE:  prdata_next = byte_of(IDENT_WORD, 2'h3);
            OFS_CELL_IDENT_BYTE0: prdata_next = byte_of(CELL_IDENT_WORD, 2'h0);
            OFS_CELL_IDENT_BYTE1: prdata_next = byte_of(CELL_IDENT_WORD, 2'h1);
            OFS_CELL_IDENT_BYTE2: prdata_next = byte_of(CELL_IDENT_WORD, 2'h2);
            OFS_CELL_IDENT_BYTE3: prdata_next = byte_of(CELL_IDENT_WORD, 2'h3);
            OFS_BURST_CTRL:       prdata_next = burst_ctrl_reg;
            OFS_BURST_STAT: begin
                prdata_next[BS_BEATS_LSB +: 5] = plan_reg.beats;
                prdata_next[BS_KIND_LSB +: 2]  = plan_reg.kind;
            end
            default: pslverr_next = 1'b1;
        endcase
        // read-back only: write data never reaches prdata
        if (apb_req.pwrite) begin
            prdata_next = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer flops: one wait-free access cycle after every setup
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else if (ce) begin
            pready_reg  <= setup_phase;
            pslverr_reg <= setup_phase && pslverr_next;
            prdata_reg  <= setup_phase ? prdata_next : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // burst control register: the only writable word
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            burst_ctrl_reg <= BURST_CTRL_RST;
        end else if (ce && access_done && apb_req.pwrite && apb_req.paddr == OFS_BURST_CTRL) begin
            burst_ctrl_reg <= apb_req.pwdata;
        end
        // identity addresses take writes without any effect
    end

    ////////////////////////////////////////////////////////////////////////////
    // burst plan follows the control register
    assign plan_next = plan_burst(dir_size_e'(burst_ctrl_reg[BC_SIZE_LSB +: 2]),
                                  burst_ctrl_reg[BC_SAME_BIT],
                                  burst_ctrl_reg[BC_COUNT_LSB +: BC_COUNT_W]);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            plan_reg <= '{kind: KIND_SINGLE, beats: BEATS_SINGLE};
        end else if (ce) begin
            plan_reg <= plan_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign prdata     = prdata_reg;
    assign pready     = pready_reg;
    assign pslverr    = pslverr_reg;
    assign burst_plan = plan_reg;

endmodule

// File: include/dir_pkg.sv
// constants and types for the dma identity register bank
package dir_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_DMA_IDENT_BYTE0  = 32'hffe0_4fe0;
    localparam logic [ADDR_W-1:0] OFS_DMA_IDENT_BYTE1  = 32'hffe0_4fe4;
    localparam logic [ADDR_W-1:0] OFS_DMA_IDENT_BYTE2  = 32'hffe0_4fe8;
    localparam logic [ADDR_W-1:0] OFS_DMA_CONFIG_BYTE  = 32'hffe0_4fec;
    localparam logic [ADDR_W-1:0] OFS_CELL_IDENT_BYTE0 = 32'hffe0_4ff0;
    localparam logic [ADDR_W-1:0] OFS_CELL_IDENT_BYTE1 = 32'hffe0_4ff4;
    localparam logic [ADDR_W-1:0] OFS_CELL_IDENT_BYTE2 = 32'hffe0_4ff8;
    localparam logic [ADDR_W-1:0] OFS_CELL_IDENT_BYTE3 = 32'hffe0_4ffc;
    localparam logic [ADDR_W-1:0] OFS_BURST_CTRL       = 32'hffe0_4fd0;
    localparam logic [ADDR_W-1:0] OFS_BURST_STAT       = 32'hffe0_4fd4;

    ////////////////////////////////////////////////////////////////////////////
    // identity word field positions
    localparam int PRODUCT_LSB    = 0;
    localparam int PRODUCT_W      = 12;
    localparam int ORIGINATOR_LSB = 12;
    localparam int ORIGINATOR_W   = 8;
    localparam int REVISION_LSB   = 20;
    localparam int REVISION_W     = 4;
    localparam int CONFIG_LSB     = 24;
    localparam int CONFIG_W       = 8;

    ////////////////////////////////////////////////////////////////////////////
    // configuration byte fields and reset encodings
    localparam int CFG_REQ_BIT       = 7;
    localparam int CFG_WIDTH_LSB     = 4;
    localparam int CFG_MASTERS_BIT   = 3;
    localparam int CFG_CHAN_LSB      = 0;
    localparam logic       CFG_REQ_16    = 1'b0;
    localparam logic [2:0] CFG_WIDTH_32  = 3'h0;
    localparam logic       CFG_MASTERS_1 = 1'b0;
    localparam logic [2:0] CFG_CHAN_2    = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // burst control register fields and reset value
    localparam int BC_SIZE_LSB  = 0;
    localparam int BC_SAME_BIT  = 2;
    localparam int BC_COUNT_LSB = 16;
    localparam int BC_COUNT_W   = 16;
    localparam logic [DATA_W-1:0] BURST_CTRL_RST = 32'h0000_0000;

    // burst status register fields
    localparam int BS_BEATS_LSB = 0;
    localparam int BS_KIND_LSB  = 8;

    // beats per burst
    localparam logic [4:0] BEATS_SINGLE = 5'h01;
    localparam logic [4:0] BEATS_WORD   = 5'h04;
    localparam logic [4:0] BEATS_HALF   = 5'h08;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_HALF,
        SIZE_WORD,
        SIZE_RSVD
    } dir_size_e;

    typedef enum logic [1:0] {
        KIND_SINGLE,
        KIND_INCR4,
        KIND_INCR8,
        KIND_UNUSED
    } dir_kind_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } dir_apb_req_s;

    typedef struct packed {
        dir_kind_e  kind;
        logic [4:0] beats;
    } dir_burst_s;

endpackage

// File: dv/dir_regs_props.sv
// assertions on the identity bank ports
`timescale 1ns/1ps
module dir_regs_props
    import dir_pkg::*;
(
    input wire logic              clock,
    input wire logic              rstn,
    input wire logic              ce,
    input wire dir_apb_req_s      apb_req,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire dir_burst_s        burst_plan
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // answered access to the identity space
    wire id_acc = pready && apb_req.paddr >= OFS_DMA_IDENT_BYTE0 && apb_req.paddr <= OFS_CELL_IDENT_BYTE3;
    wire rd_acc = pready && !apb_req.pwrite;
    // handshake, identity reads and identity writes
    ready_after_setup_a: assert property (apb_req.psel && !apb_req.penable && ce |=> pready)
        else $error("no ready after setup");
    ready_single_a: assert property (pready && ce |=> !pready)
        else $error("ready longer than one cycle");
    idle_quiet_a: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("answer outside access");
    config_zero_a: assert property (rd_acc && apb_req.paddr == OFS_DMA_CONFIG_BYTE
        |-> prdata == 32'h0000_0000)
        else $error("config byte not zero");
    ident_upper_a: assert property (rd_acc && id_acc |-> prdata[31:8] == 24'h00_0000 && !pslverr)
        else $error("identity read bad upper bits");
    ident_write_ok_a: assert property (pready && apb_req.pwrite && id_acc |-> !pslverr)
        else $error("identity write flagged");
    // burst plan
    no_incr16_a: assert property (burst_plan.beats != 5'h10 && burst_plan.kind != KIND_UNUSED)
        else $error("sixteen beat plan");
    incr4_pair_a: assert property (burst_plan.kind == KIND_INCR4 |-> burst_plan.beats == BEATS_WORD)
        else $error("incr4 beats wrong");
    incr8_pair_a: assert property (burst_plan.kind == KIND_INCR8 |-> burst_plan.beats == BEATS_HALF)
        else $error("incr8 beats wrong");
endmodule
bind dir_regs dir_regs_props dir_regs_props_inst (.clock(clock), .rstn(rstn), .ce(ce), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .burst_plan(burst_plan));

// File: dv/dir_regs_tb_top.sv
// self-checking bench for the identity register bank
`timescale 1ns/1ps
module dir_regs_tb_top;
    import dir_pkg::*;
    localparam logic [11:0] PC = 12'h6b4;       // arbitrary value
    localparam logic [7:0]  OC = 8'h9e;         // arbitrary value
    localparam logic [3:0]  RV = 4'h3;          // arbitrary value
    localparam logic [31:0] CW = 32'h5a3c_72e1; // arbitrary value
    typedef struct packed {logic [1:0] sz; logic same; logic [15:0] cnt;
                           dir_kind_e kind; logic [4:0] beats;} dir_case_s;
    logic         clock = 1'b0;
    logic         rstn = 1'b0;
    logic         ce = 1'b1;
    dir_apb_req_s apb_req = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    dir_burst_s   burst_plan;
    int           err_total = 0;
    int           checks_done = 0;
    int           cyc = 0;
    logic [31:0]  rd;
    logic         er;
    logic [7:0]   idb [8];
    dir_case_s    cs [7];
    dir_regs #(.PRODUCT_CODE(PC), .ORIGINATOR_CODE(OC), .REVISION(RV), .CELL_IDENT_WORD(CW)) dir_regs_inst (
        .clock(clock), .rstn(rstn), .ce(ce), .apb_req(apb_req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .burst_plan(burst_plan));
    // clock
    always #12.5 clock = ~clock;
    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer, left selected so another may follow at once
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, w, a, d}; // whole-word accesses only
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
    endtask
    task automatic idle();
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge clock);
    endtask
    // main sequence
    initial begin
        idb = '{PC[7:0], {OC[3:0], PC[11:8]}, {RV, OC[7:4]}, 8'h00, CW[7:0], CW[15:8], CW[23:16], CW[31:24]};
        cs = '{'{2'h2, 1'b1, 16'h0004, KIND_INCR4, BEATS_WORD}, '{2'h2, 1'b1, 16'h0003, KIND_SINGLE, BEATS_SINGLE},
               '{2'h1, 1'b1, 16'h0008, KIND_INCR8, BEATS_HALF}, '{2'h1, 1'b1, 16'h0007, KIND_SINGLE, BEATS_SINGLE},
               '{2'h0, 1'b1, 16'h0010, KIND_SINGLE, BEATS_SINGLE}, '{2'h2, 1'b0, 16'h0064, KIND_SINGLE, BEATS_SINGLE},
               '{2'h1, 1'b0, 16'h0008, KIND_SINGLE, BEATS_SINGLE}};
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, OFS_DMA_IDENT_BYTE0 + 32'(4 * i), 32'h0000_0000);
            chk(rd, {24'h00_0000, idb[i]});
            xfer(1'b1, OFS_DMA_IDENT_BYTE0 + 32'(4 * i), 32'hffff_ffff);
            chk({31'h0000_0000, er}, 32'h0000_0000);
            xfer(1'b0, OFS_DMA_IDENT_BYTE0 + 32'(4 * i), 32'h0000_0000);
            chk(rd, {24'h00_0000, idb[i]});
        end
        for (int k = 0; k < 2; k++) begin
            xfer(1'b0, k ? 32'h0000_0fe0 : 32'hffe0_4fdc, 32'h0000_0000);
            chk({er, rd[30:0]}, 32'h8000_0000);
        end
        xfer(1'b0, OFS_BURST_CTRL, 32'h0000_0000);
        chk(rd, BURST_CTRL_RST);
        idle();
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, OFS_BURST_CTRL, {cs[i].cnt, 13'h0000, cs[i].same, cs[i].sz});
            idle();
            xfer(1'b0, OFS_BURST_STAT, 32'h0000_0000);
            chk(rd & 32'h0000_031f, {22'h00_0000, cs[i].kind, 3'h0, cs[i].beats});
            chk({25'h000_0000, burst_plan}, {25'h000_0000, cs[i].kind, cs[i].beats});
            idle();
        end
        // clock enable low freezes the plan, raising it lets the plan follow
        xfer(1'b1, OFS_BURST_CTRL, {16'h0004, 13'h0000, 1'b1, 2'h2});
        ce <= 1'b0;
        idle();
        repeat (2) @(posedge clock);
        chk({25'h000_0000, burst_plan}, {25'h000_0000, KIND_SINGLE, BEATS_SINGLE});
        ce <= 1'b1;
        repeat (2) @(posedge clock);
        chk({25'h000_0000, burst_plan}, {25'h000_0000, KIND_INCR4, BEATS_WORD});
        final_report();
    end
endmodule
